//--- tfwc_capture.sv
// Triggered waveform capture for several probe channels behind an APB slave.
// Assumes the sample stream is synchronous to pclk; trigger pins are not.
`timescale 1ns/1ps
`default_nettype none

module tfwc_capture
    import tfwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TFWC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic [TFWC_NCH-1:0][TFWC_SAMPLE_W-1:0] sample_data,
    input wire logic [TFWC_NCH-1:0] trig_pin,
    output var tfwc_wr_t [TFWC_NCH-1:0] wave_wr,
    output logic irq
);

    tfwc_top_t s_q;
    tfwc_top_t s_d;

    function automatic logic [31:0] chan_total(input tfwc_chan_t c);
        chan_total = 32'(c.len) * 32'(c.points);
    endfunction

    // Every recorded sample leaves the ring one full depth late, so the
    // number of samples to pass over is the offset plus the depth less one.
    // Offsets beyond the ring's reach are clamped rather than refused: the
    // capture still runs, but starts later than software asked for.
    function automatic logic [31:0] skip_start(input logic signed [31:0] o);
        logic signed [31:0] eff;
        eff = (o < TFWC_MIN_OFFSET) ? TFWC_MIN_OFFSET : o;
        skip_start = 32'(eff + 32'(TFWC_HIST_DEPTH) - 32'sd1);
    endfunction

    always_comb
    begin
        tfwc_top_t n;
        tfwc_chan_t ch;
        logic wr_acc;
        logic setup;
        logic is_sel;
        logic arm;
        logic clr;
        logic frc;
        logic edge_ev;
        logic [TFWC_SAMPLE_W-1:0] dly;
        logic [TFWC_IRQ_W-1:0] ev;
        logic [TFWC_IRQ_W-1:0] clr_mask;
        tfwc_chan_t cur;
        n = s_q;
        ch = s_q.chan[0];
        cur = s_q.chan[s_q.sel];
        wr_acc = psel & penable & s_q.pready & pwrite;
        setup = psel & ~penable & ~s_q.pready;
        is_sel = 1'b0;
        arm = 1'b0;
        clr = 1'b0;
        frc = 1'b0;
        edge_ev = 1'b0;
        dly = '0;
        ev = '0;
        clr_mask = '0;

        if (wr_acc && paddr == TFWC_REG_CHAN_SEL)
        begin
            n.sel = pwdata[0:0];
        end
        if (wr_acc && paddr == TFWC_REG_IRQ_ENABLE)
        begin
            n.irq_en = pwdata[TFWC_IRQ_W-1:0];
        end
        if (wr_acc && paddr == TFWC_REG_IRQ_CLEAR)
        begin
            clr_mask = pwdata[TFWC_IRQ_W-1:0];
        end

        for (int c = 0; c < TFWC_NCH; c++)
        begin
            ch = s_q.chan[c];
            is_sel = (32'(s_q.sel) == c);
            n.wr[c].valid = 1'b0;
            // Settings and commands reach only the selected channel. [R10]
            arm = wr_acc & is_sel & (paddr == TFWC_REG_CMD)
                & pwdata[TFWC_CMD_ARM_BIT];
            clr = wr_acc & is_sel & (paddr == TFWC_REG_CMD)
                & pwdata[TFWC_CMD_CLEAR_BIT];
            frc = wr_acc & is_sel & (paddr == TFWC_REG_CMD)
                & pwdata[TFWC_CMD_FORCE_BIT];
            if (wr_acc && is_sel && paddr == TFWC_REG_BEGIN)
            begin
                n.chan[c].offset = pwdata; // [R07]
            end
            if (wr_acc && is_sel && paddr == TFWC_REG_LENGTH)
            begin
                n.chan[c].len = pwdata[TFWC_LEN_W-1:0]; // [R08]
            end
            if (wr_acc && is_sel && paddr == TFWC_REG_POINTS)
            begin
                n.chan[c].points = pwdata[TFWC_LEN_W-1:0]; // [R09]
            end

            // The second and third stages of the synchroniser feed the edge test.
            n.chan[c].trig_s1 = trig_pin[c];
            n.chan[c].trig_s2 = ch.trig_s1;
            n.chan[c].trig_s3 = ch.trig_s2;
            edge_ev = ch.trig_s2 & ~ch.trig_s3;

            // The ring always runs, so the oldest entry is the sample from
            // exactly one history depth ago. [R15]
            if (sample_valid)
            begin
                dly = ch.hist[ch.wp];
                n.chan[c].hist[ch.wp] = sample_data[c];
                n.chan[c].wp = ch.wp + 1'b1;
            end
            else
            begin
                dly = '0;
            end

            // A pending trigger is tied to the next sample on the stream.
            if (ch.fsm == TFWC_ARMED && sample_valid)
            begin
                n.chan[c].pend = 1'b0;
            end
            if ((edge_ev && ch.fsm == TFWC_ARMED) || (frc &&
                (ch.fsm == TFWC_ARMED || ch.fsm == TFWC_ARMING)))
            begin
                n.chan[c].pend = 1'b1; // [R13]
            end

            case (ch.fsm)
                TFWC_IDLE:
                begin
                end
                TFWC_ARMING:
                begin
                    n.chan[c].progress = '0;
                    n.chan[c].ptcnt = '0;
                    n.chan[c].fsm = (ch.points == '0) ? TFWC_DONE
                        : TFWC_ARMED; // [R12]
                end
                TFWC_ARMED:
                begin
                    if (ch.pend && sample_valid)
                    begin
                        n.chan[c].fsm = TFWC_TRIGGERED; // [R13]
                        n.chan[c].ptcnt = ch.ptcnt + 1'b1; // [R14]
                        // Negative offsets reach back into the ring. [R01]
                        n.chan[c].skip = skip_start(ch.offset);
                        n.chan[c].left = ch.len; // [R02]
                        ev[TFWC_IRQ_PT_LSB + c] = 1'b1;
                    end
                end
                TFWC_TRIGGERED:
                begin
                    if (ch.left == '0)
                    begin
                        if (ch.ptcnt == ch.points)
                        begin
                            n.chan[c].fsm = TFWC_DONE; // [R04] [R06]
                            ev[TFWC_IRQ_DONE_LSB + c] = 1'b1;
                        end
                        else
                        begin
                            n.chan[c].fsm = TFWC_ARMED;
                        end
                    end
                    else if (sample_valid)
                    begin
                        if (ch.skip != '0)
                        begin
                            n.chan[c].skip = ch.skip - 32'd1; // [R01]
                        end
                        else
                        begin
                            n.wr[c].valid = 1'b1;
                            n.wr[c].addr = ch.progress;
                            n.wr[c].data = dly;
                            n.chan[c].left = ch.left - 1'b1; // [R02]
                            n.chan[c].progress = ch.progress + 32'd1; // [R05]
                        end
                    end
                end
                TFWC_DONE:
                begin
                end
                default:
                begin
                    n.chan[c].fsm = TFWC_IDLE;
                end
            endcase

            // Clear takes priority when both bits are written together.
            if (arm)
            begin
                n.chan[c].fsm = TFWC_ARMING; // [R12]
                n.chan[c].pend = 1'b0;
            end
            if (clr)
            begin
                n.chan[c].fsm = TFWC_IDLE; // [R12]
                n.chan[c].pend = 1'b0;
            end
        end

        // A new event wins over a clear written in the same cycle.
        n.irq_st = (s_q.irq_st & ~clr_mask) | ev;
        n.irq = |(n.irq_st & n.irq_en);

        // Reads are decoded in the setup cycle so that prdata is a register.
        n.pready = 1'b0;
        n.pslverr = 1'b0;
        if (setup)
        begin
            n.pready = 1'b1;
            n.prdata = '0;
            case (paddr)
                TFWC_REG_CHAN_SEL: n.prdata = 32'(s_q.sel);
                TFWC_REG_CMD: n.prdata = '0;
                TFWC_REG_BEGIN: n.prdata = cur.offset; // [R07]
                TFWC_REG_LENGTH: n.prdata = 32'(cur.len); // [R08]
                TFWC_REG_POINTS: n.prdata = 32'(cur.points); // [R09]
                TFWC_REG_TOTAL: n.prdata = chan_total(cur); // [R03]
                TFWC_REG_PROGRESS: n.prdata = cur.progress; // [R05]
                TFWC_REG_PTPROG: n.prdata = 32'(cur.ptcnt); // [R14]
                TFWC_REG_STATE: n.prdata = 32'(cur.fsm); // [R11]
                TFWC_REG_IRQ_STATUS: n.prdata = 32'(s_q.irq_st);
                TFWC_REG_IRQ_CLEAR: n.prdata = '0;
                TFWC_REG_IRQ_ENABLE: n.prdata = 32'(s_q.irq_en);
                default: n.pslverr = 1'b1;
            endcase
        end
        s_d = n;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign wave_wr = s_q.wr;
    assign irq = s_q.irq;

endmodule

`default_nettype wire

//--- tfwc_pkg.sv
// Constants, register map and carrier types of the triggered waveform capture.
// Assumes one APB clock domain that also carries the sample stream.
// How it works
// R01: Each segment starts at a signed sample offset from the trigger sample.
// R02: Each trigger point records exactly the configured number of samples.
// R03: Total length reads as samples per point times trigger points.
// R04: Completion only after the configured number of triggers were accepted.
// R05: Running count of written samples is readable at any time.
// R06: At completion the progress count equals the total length.
// R07: Start offset reads back the signed value last written.
// R08: Segment length reads back the value last written.
// R09: Trigger point count reads back the value last written.
// R10: Every channel keeps its own settings and progress.
// R11: Five readable states: idle, arming, armed, triggered, completed.
// R12: Arm leads from any state through arming to armed, or to completed with zero points; clear leads to idle.
// R13: Forced trigger enters triggered regardless of trigger source.
// R14: Processed trigger points are counted and equal the point count at end.
// R15: A sample history covers the most negative allowed offset.
// R16: Software changes settings only while idle, before arming.
package tfwc_pkg;
    localparam int TFWC_NCH = 2;
    localparam int TFWC_HIST_DEPTH = 128;
    localparam int TFWC_HIST_AW = 7;
    localparam int TFWC_SAMPLE_W = 16;
    localparam int TFWC_LEN_W = 16;
    localparam int TFWC_ADDR_W = 8;
    localparam int TFWC_IRQ_W = 4;
    localparam int TFWC_IRQ_DONE_LSB = 0;
    localparam int TFWC_IRQ_PT_LSB = 2;
    localparam logic signed [31:0] TFWC_MIN_OFFSET = 32'shffffff81;

    localparam logic [7:0] TFWC_REG_CHAN_SEL = 8'h00;
    localparam logic [7:0] TFWC_REG_CMD = 8'h04;
    localparam logic [7:0] TFWC_REG_BEGIN = 8'h08;
    localparam logic [7:0] TFWC_REG_LENGTH = 8'h0c;
    localparam logic [7:0] TFWC_REG_POINTS = 8'h10;
    localparam logic [7:0] TFWC_REG_TOTAL = 8'h14;
    localparam logic [7:0] TFWC_REG_PROGRESS = 8'h18;
    localparam logic [7:0] TFWC_REG_PTPROG = 8'h1c;
    localparam logic [7:0] TFWC_REG_STATE = 8'h20;
    localparam logic [7:0] TFWC_REG_IRQ_STATUS = 8'h24;
    localparam logic [7:0] TFWC_REG_IRQ_CLEAR = 8'h28;
    localparam logic [7:0] TFWC_REG_IRQ_ENABLE = 8'h2c;

    localparam int TFWC_CMD_ARM_BIT = 0;
    localparam int TFWC_CMD_CLEAR_BIT = 1;
    localparam int TFWC_CMD_FORCE_BIT = 2;

    typedef enum logic [2:0] {
        TFWC_IDLE = 3'b000,
        TFWC_ARMING = 3'b001,
        TFWC_ARMED = 3'b010,
        TFWC_TRIGGERED = 3'b011,
        TFWC_DONE = 3'b100
    } tfwc_state_t;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        logic [TFWC_SAMPLE_W-1:0] data;
    } tfwc_wr_t;

    typedef struct packed {
        tfwc_state_t fsm;
        logic signed [31:0] offset;
        logic [TFWC_LEN_W-1:0] len;
        logic [TFWC_LEN_W-1:0] points;
        logic [31:0] progress;
        logic [TFWC_LEN_W-1:0] ptcnt;
        logic [31:0] skip;
        logic [TFWC_LEN_W-1:0] left;
        logic pend;
        logic trig_s1;
        logic trig_s2;
        logic trig_s3;
        logic [TFWC_HIST_AW-1:0] wp;
        logic [TFWC_HIST_DEPTH-1:0][TFWC_SAMPLE_W-1:0] hist;
    } tfwc_chan_t;

    typedef struct packed {
        tfwc_chan_t [TFWC_NCH-1:0] chan;
        tfwc_wr_t [TFWC_NCH-1:0] wr;
        logic [0:0] sel;
        logic [TFWC_IRQ_W-1:0] irq_st;
        logic [TFWC_IRQ_W-1:0] irq_en;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } tfwc_top_t;
endpackage

//--- tfwc_sample_src.sv
// Sample stream source standing in for the probe front end.
// Assumes the capture block samples on the rising edge of pclk.
`timescale 1ns/1ps
`default_nettype none
module tfwc_sample_src
    import tfwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic sample_valid,
    output logic [TFWC_NCH-1:0][TFWC_SAMPLE_W-1:0] sample_data
);
    logic [15:0] cnt_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_q <= 16'h0000;
        else
            cnt_q <= cnt_q + 16'h0001;
    end
    // Slow mode thins the stream to test a gappy front end.
    assign sample_valid = presetn && (!slow || cnt_q[0]);
    assign sample_data[0] = cnt_q;
    assign sample_data[1] = ~cnt_q;
endmodule
`default_nettype wire

//--- tfwc_capture_assertions.sv
// Port checker for the capture block.
// Assumes one clock domain and an APB master that waits for pready.
`timescale 1ns/1ps
`default_nettype none
module tfwc_capture_assertions
    import tfwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [TFWC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sample_valid,
    input wire tfwc_wr_t [TFWC_NCH-1:0] wave_wr,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ready_after_setup;
        psel && !penable |=> pready;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("late pready");
    property p_ready_one;
        pready |=> !pready;
    endproperty
    a_ready_one: assert property (p_ready_one) else $error("long pready");
    property p_err_with_ready;
        pslverr |-> pready && psel;
    endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("stray pslverr");
    property p_cmd_reads_zero;
        pready && !pwrite && paddr == TFWC_REG_CMD |-> prdata == 32'h0;
    endproperty
    a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("cmd read");
    property p_irq_off;
        pready && pwrite && paddr == TFWC_REG_IRQ_ENABLE && pwdata == 32'h0
            |-> ##2 !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq while masked");
    property p_wr_follows_sample;
        wave_wr[0].valid || wave_wr[1].valid |-> $past(sample_valid);
    endproperty
    a_wr_follows_sample: assert property (p_wr_follows_sample) else $error("no sample");
    property p_addr_step;
        wave_wr[0].valid && $past(wave_wr[0].valid)
            |-> wave_wr[0].addr == $past(wave_wr[0].addr) + 32'h1;
    endproperty
    a_addr_step: assert property (p_addr_step) else $error("progress skip");
    property p_data_step;
        wave_wr[0].valid && $past(wave_wr[0].valid)
            |-> wave_wr[0].data == $past(wave_wr[0].data) + 16'h1;
    endproperty
    a_data_step: assert property (p_data_step) else $error("sample skip");
endmodule
bind tfwc_capture tfwc_capture_assertions tfwc_capture_assertions_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_valid(sample_valid),
    .wave_wr(wave_wr), .irq(irq));
`default_nettype wire

//--- tfwc_capture_test.sv
// Register level test of the capture block with a counting sample source.
// Assumes the partner stream is free running from reset release.
`timescale 1ns/1ps
`default_nettype none
module tfwc_capture_test
    import tfwc_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, slow;
    logic err, sample_valid;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [TFWC_NCH-1:0][TFWC_SAMPLE_W-1:0] sample_data;
    logic [TFWC_NCH-1:0] trig_pin;
    tfwc_wr_t [TFWC_NCH-1:0] wave_wr;
    logic [15:0] t0, first0, last0;
    logic [31:0] off[2] = '{32'hfffffffe, 32'h5};
    logic [31:0] len[2] = '{32'h3, 32'h2};
    logic [31:0] pts[2] = '{32'h2, 32'h1};
    int fails, num_checks, wcnt[2];
    tfwc_capture tfwc_capture_i (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_valid(sample_valid),
        .sample_data(sample_data), .trig_pin(trig_pin),
        .wave_wr(wave_wr), .irq(irq));
    tfwc_sample_src tfwc_sample_src_i (.pclk(pclk), .presetn(presetn),
        .slow(slow), .sample_valid(sample_valid), .sample_data(sample_data));
    always #4 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (wave_wr[0].valid === 1'b1 && wcnt[0] == 0)
            first0 = wave_wr[0].data;
        if (wave_wr[0].valid === 1'b1)
            last0 = wave_wr[0].data;
        for (int c = 0; c < 2; c++)
            wcnt[c] += (wave_wr[c].valid === 1'b1);
    end
    task automatic report_and_stop();
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        fails += (n >= 50);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rdata, exp);
    endtask
    task automatic wait_st(input logic [31:0] exp);
        apb(1'b0, TFWC_REG_STATE, 32'h0);
        for (int i = 0; i < 300 && rdata !== exp; i++)
            apb(1'b0, TFWC_REG_STATE, 32'h0);
        chk(rdata, exp);
    endtask
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {trig_pin, slow, fails, num_checks} = '0;
        wcnt = '{0, 0};
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(TFWC_REG_STATE, 32'h0);
        rd(TFWC_REG_CMD, 32'h0);
        rd(8'h40, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int c = 0; c < 2; c++)
        begin
            wr(TFWC_REG_CHAN_SEL, c);
            wr(TFWC_REG_BEGIN, off[c]);
            wr(TFWC_REG_LENGTH, len[c]);
            wr(TFWC_REG_POINTS, pts[c]);
        end
        for (int c = 0; c < 2; c++)
        begin
            wr(TFWC_REG_CHAN_SEL, c);
            rd(TFWC_REG_BEGIN, off[c]);
            rd(TFWC_REG_LENGTH, len[c]);
            rd(TFWC_REG_POINTS, pts[c]);
            rd(TFWC_REG_TOTAL, len[c] * pts[c]);
        end
        wr(TFWC_REG_IRQ_ENABLE, 32'h1);
        wr(TFWC_REG_CHAN_SEL, 32'h0);
        wr(TFWC_REG_CMD, 32'h1);
        rd(TFWC_REG_STATE, 32'h2);
        wr(TFWC_REG_CMD, 32'h4);
        t0 = sample_data[0] + 16'h1;
        for (int i = 0; i < 900 && wcnt[0] < 3; i++)
            @(posedge pclk);
        chk({16'h0, first0}, {16'h0, t0 - 16'h2});
        rd(TFWC_REG_STATE, 32'h2);
        rd(TFWC_REG_PTPROG, 32'h1);
        wr(TFWC_REG_CMD, 32'h4);
        wait_st(32'h4);
        rd(TFWC_REG_PROGRESS, 32'h6);
        rd(TFWC_REG_PTPROG, 32'h2);
        chk(wcnt[0], 32'h6);
        chk({31'h0, irq}, 32'h1);
        wr(TFWC_REG_IRQ_CLEAR, 32'h1);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        rd(TFWC_REG_IRQ_STATUS, 32'h4);
        wr(TFWC_REG_CHAN_SEL, 32'h1);
        slow <= 1'b1;
        wr(TFWC_REG_CMD, 32'h1);
        trig_pin <= 2'b10;
        repeat (4) @(posedge pclk);
        trig_pin <= 2'b00;
        wait_st(32'h4);
        rd(TFWC_REG_PROGRESS, 32'h2);
        chk(wcnt[1], 32'h2);
        slow <= 1'b0;
        wr(TFWC_REG_CMD, 32'h1);
        rd(TFWC_REG_STATE, 32'h2);
        rd(TFWC_REG_PTPROG, 32'h0);
        wr(TFWC_REG_CMD, 32'h2);
        rd(TFWC_REG_STATE, 32'h0);
        wr(TFWC_REG_CHAN_SEL, 32'h0);
        rd(TFWC_REG_PROGRESS, 32'h6);
        wr(TFWC_REG_CMD, 32'h2);
        rd(TFWC_REG_STATE, 32'h0);
        wr(TFWC_REG_BEGIN, 32'hffffff38);
        wr(TFWC_REG_LENGTH, 32'h1);
        wr(TFWC_REG_POINTS, 32'h1);
        // The ring must hold only full-rate samples before the trigger.
        repeat (130) @(posedge pclk);
        wr(TFWC_REG_CMD, 32'h1);
        wr(TFWC_REG_CMD, 32'h4);
        t0 = sample_data[0] + 16'h1;
        wait_st(32'h4);
        chk({16'h0, last0}, {16'h0, t0 - 16'h7f});
        rd(TFWC_REG_PROGRESS, 32'h1);
        rd(TFWC_REG_BEGIN, 32'hffffff38);
        chk({31'h0, irq}, 32'h1);
        wr(TFWC_REG_IRQ_ENABLE, 32'h0);
        rd(TFWC_REG_IRQ_ENABLE, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(TFWC_REG_CMD, 32'h2);
        wr(TFWC_REG_POINTS, 32'h0);
        wr(TFWC_REG_CMD, 32'h1);
        rd(TFWC_REG_STATE, 32'h4);
        rd(TFWC_REG_PROGRESS, 32'h0);
        rd(TFWC_REG_TOTAL, 32'h0);
        report_and_stop();
    end
    initial
    begin
        #400000;
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
